// ===== rtl/msi_vendor_capability_regs.sv
// Interrupt-message and vendor capability configuration registers of a switch port
`timescale 1ns/1ns
`include "msi_vendor_cap_map.svh"
module msi_vendor_capability_regs
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire msi_vendor_cap_pkg::cfg_req_t i_cfg_req,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_ack,
   input wire logic i_dflt_load,
   input wire msi_vendor_cap_pkg::replay_cfg_t i_dflt_replay,
   input wire logic i_event,
   input wire logic i_msg_done,
   output msi_vendor_cap_pkg::msg_write_t o_msg_write,
   output logic o_legacy_int_allow,
   input wire logic i_legacy_int,
   output logic o_legacy_int,
   output logic o_replay_user_en,
   output logic [11:0] o_replay_user_val,
   output logic o_pm_cap_dis,
   output logic o_msi_cap_dis
);
   import msi_vendor_cap_pkg::*;

   logic msi_en_reg;
   logic [2:0] mm_enable_reg;
   logic [31:0] addr_reg;
   logic [31:0] uaddr_reg;
   logic [15:0] data_reg;
   logic [31:0] test0_reg;
   logic [31:0] test1_reg;
   replay_cfg_t replay_reg;
   msg_state_t state_reg;
   msg_write_t msg_reg;
   logic pending_reg;
   logic [31:0] rdata_next;
   logic [31:0] ctrl_word;
   logic [31:0] replay_word;
   logic wr;
   logic rd_req;
   logic wr_ctrl;
   logic wr_addr;
   logic wr_uaddr;
   logic wr_data;
   logic wr_test0;
   logic wr_test1;
   logic wr_replay;
   logic [31:0] data_merged;
   logic [31:0] upper_eff;

   // Byte-lane merge: only bits under a set byte enable and mask change
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
      input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] lanes;
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
      merge = (old_v & ~lanes) | (new_v & lanes);
   endfunction

   // One decode for every write strobe, so no register can miss the valid term
   function automatic logic reg_hit(input cfg_req_t r, input logic [7:0] ofs);
      reg_hit = r.valid & r.write & (r.offset == ofs);
   endfunction

   assign wr = i_cfg_req.valid & i_cfg_req.write;
   assign rd_req = i_cfg_req.valid & ~i_cfg_req.write;
   assign wr_ctrl = reg_hit(i_cfg_req, `OFS_MSG_CTRL);
   assign wr_addr = reg_hit(i_cfg_req, `OFS_MSG_ADDR);
   assign wr_uaddr = reg_hit(i_cfg_req, `OFS_MSG_UADDR);
   assign wr_data = reg_hit(i_cfg_req, `OFS_MSG_DATA);
   assign wr_test0 = reg_hit(i_cfg_req, `OFS_TEST0);
   assign wr_test1 = reg_hit(i_cfg_req, `OFS_TEST1);
   assign wr_replay = reg_hit(i_cfg_req, `OFS_REPLAY);
   // Upper half is reserved, so only the low lanes can land
   assign data_merged = merge({16'h0000, data_reg}, i_cfg_req.wdata, i_cfg_req.byte_en,
      32'h0000ffff);
   // Upper target half only counts while the 64-bit capable bit is up
   assign upper_eff = ctrl_word[`BIT_64B_CAP] ? uaddr_reg : 32'h00000000;

   always_comb
   begin
      ctrl_word = 32'h00000000;
      ctrl_word[7:0] = `MSI_CAP_ID;
      ctrl_word[15:8] = `MSI_NEXT_PTR;
      ctrl_word[`BIT_MSI_EN] = msi_en_reg;
      ctrl_word[19:17] = `MSI_MM_CAPABLE;
      ctrl_word[22:20] = mm_enable_reg;
      ctrl_word[`BIT_64B_CAP] = 1'b1;
   end

   always_comb
   begin
      replay_word = 32'h00000000;
      replay_word[11:0] = replay_reg.user_replay;
      replay_word[`BIT_USER_REPLAY_EN] = replay_reg.user_replay_en;
      replay_word[`BIT_PM_CAP_DIS] = replay_reg.pm_cap_dis;
      replay_word[`BIT_MSI_CAP_DIS] = replay_reg.msi_cap_dis;
   end

   always_comb
   begin
      unique case (i_cfg_req.offset)
         `OFS_MSG_CTRL: rdata_next = ctrl_word;
         `OFS_MSG_ADDR: rdata_next = addr_reg;
         `OFS_MSG_UADDR: rdata_next = uaddr_reg;
         `OFS_MSG_DATA: rdata_next = {16'h0000, data_reg};
         `OFS_VEND_CAP:
            rdata_next = {`VEND_LENGTH, `VEND_NEXT_PTR, `VEND_CAP_ID};
         `OFS_TEST0: rdata_next = test0_reg;
         `OFS_TEST1: rdata_next = test1_reg;
         `OFS_REPLAY: rdata_next = replay_word;
         default: rdata_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         o_cfg_rdata <= 32'h00000000;
         o_cfg_ack <= 1'b0;
      end
      else
      begin
         o_cfg_ack <= i_cfg_req.valid;
         if (rd_req)
            o_cfg_rdata <= rdata_next;
      end
   end

   // Interrupt-message control
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         msi_en_reg <= 1'b0;
         mm_enable_reg <= 3'h0;
      end
      else if (wr_ctrl && i_cfg_req.byte_en[2])
      begin
         msi_en_reg <= i_cfg_req.wdata[`BIT_MSI_EN];
         mm_enable_reg <= i_cfg_req.wdata[22:20];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         addr_reg <= 32'h00000000;
         uaddr_reg <= 32'h00000000;
         data_reg <= 16'h0000;
      end
      else if (wr)
      begin
         if (wr_addr)
            addr_reg <= merge(addr_reg, i_cfg_req.wdata, i_cfg_req.byte_en, `ADDR_MASK);
         if (wr_uaddr)
            uaddr_reg <= merge(uaddr_reg, i_cfg_req.wdata, i_cfg_req.byte_en, 32'hffffffff);
         if (wr_data)
            data_reg <= data_merged[15:0];
      end
   end

   // Test-only words; plain storage, only the config read mux reads them
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         test0_reg <= `TEST0_RST;
         test1_reg <= `TEST1_RST;
      end
      else if (wr)
      begin
         if (wr_test0)
            test0_reg <= merge(test0_reg, i_cfg_req.wdata, i_cfg_req.byte_en, 32'hffffffff);
         if (wr_test1)
            test1_reg <= merge(test1_reg, i_cfg_req.wdata, i_cfg_req.byte_en, 32'hffffffff);
      end
   end

   // Default load beats a same-cycle software write; disable flags are read-only to software
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         replay_reg <= '0;
      else if (i_dflt_load)
         replay_reg <= i_dflt_replay;
      else if (wr_replay)
      begin
         if (i_cfg_req.byte_en[0])
            replay_reg.user_replay[7:0] <= i_cfg_req.wdata[7:0];
         if (i_cfg_req.byte_en[1])
         begin
            replay_reg.user_replay[11:8] <= i_cfg_req.wdata[11:8];
            replay_reg.user_replay_en <= i_cfg_req.wdata[`BIT_USER_REPLAY_EN];
         end
      end
   end

   assign o_replay_user_en = replay_reg.user_replay_en;
   assign o_replay_user_val = replay_reg.user_replay;
   assign o_pm_cap_dis = replay_reg.pm_cap_dis;
   assign o_msi_cap_dis = replay_reg.msi_cap_dis;
   assign o_legacy_int_allow = ~msi_en_reg;
   assign o_legacy_int = i_legacy_int & ~msi_en_reg;
   assign o_msg_write = msg_reg;

   // Message issue: one event held pending while a write is outstanding
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         state_reg <= MSG_IDLE;
         msg_reg <= '0;
         pending_reg <= 1'b0;
      end
      else
      begin
         if (!msi_en_reg)
            pending_reg <= 1'b0;
         else if (i_event)
            pending_reg <= 1'b1;
         else if (state_reg == MSG_IDLE && pending_reg)
            pending_reg <= 1'b0;
         unique case (state_reg)
            MSG_IDLE:
               if (msi_en_reg && pending_reg)
               begin
                  state_reg <= MSG_ISSUE;
                  msg_reg.valid <= 1'b1;
                  msg_reg.addr <= {upper_eff, addr_reg};
                  msg_reg.data <= data_reg;
               end
            MSG_ISSUE:
               if (i_msg_done)
               begin
                  state_reg <= MSG_IDLE;
                  msg_reg.valid <= 1'b0;
               end
            default:
            begin
               // Unused code: back to idle with no write outstanding
               state_reg <= MSG_IDLE;
               msg_reg.valid <= 1'b0;
            end
         endcase
      end
   end

   AST_NO_MSG_DISABLED: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !msi_en_reg && state_reg == MSG_IDLE |=> !o_msg_write.valid)
      else $error("Message issued while disabled");
   AST_LEGACY_BLOCKED: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      msi_en_reg |-> !o_legacy_int && !o_legacy_int_allow)
      else $error("Legacy interrupt while messages enabled");
   AST_CTRL_CONST: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_cfg_req.valid && !i_cfg_req.write && i_cfg_req.offset == `OFS_MSG_CTRL |=>
      o_cfg_rdata[`BIT_64B_CAP] && o_cfg_rdata[7:0] == `MSI_CAP_ID)
      else $error("Control word constants wrong");
   AST_ADDR_LOW_ZERO: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      addr_reg[1:0] == 2'b00)
      else $error("Address low bits not zero");
   AST_VEND_READ: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_cfg_req.valid && !i_cfg_req.write && i_cfg_req.offset == `OFS_VEND_CAP |=>
      o_cfg_rdata == 32'h0034b009 && o_cfg_ack)
      else $error("Vendor capability header wrong");
   AST_REPLAY_WRITE: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr && !i_dflt_load && i_cfg_req.offset == `OFS_REPLAY && i_cfg_req.byte_en == 4'hf |=>
      o_replay_user_val == $past(i_cfg_req.wdata[11:0]) &&
      o_replay_user_en == $past(i_cfg_req.wdata[`BIT_USER_REPLAY_EN]))
      else $error("Replay write not taken");
   AST_DFLT_LOAD: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_dflt_load |=> o_msi_cap_dis == $past(i_dflt_replay.msi_cap_dis) &&
      o_pm_cap_dis == $past(i_dflt_replay.pm_cap_dis))
      else $error("Default load not applied");
   AST_MSG_PAYLOAD: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      $rose(o_msg_write.valid) |-> o_msg_write.data == $past(data_reg) &&
      o_msg_write.addr[31:0] == $past(addr_reg))
      else $error("Message payload mismatch");
   AST_MSG_HOLD: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_msg_write.valid && !i_msg_done |=> o_msg_write.valid && $stable(o_msg_write.addr))
      else $error("Message dropped before done");

   AST_MSI_NEXT_READ: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      rd_req && i_cfg_req.offset == `OFS_MSG_CTRL |=>
      o_cfg_rdata[15:8] == `MSI_NEXT_PTR)
      else $error("Capability chain pointer wrong");
   AST_CTRL_RSVD: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      rd_req && i_cfg_req.offset == `OFS_MSG_CTRL |=>
      o_cfg_rdata[31:24] == 8'h00)
      else $error("Control reserved byte not zero");
   AST_VEND_NEXT: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      rd_req && i_cfg_req.offset == `OFS_VEND_CAP |=>
      o_cfg_rdata[15:8] == `VEND_NEXT_PTR)
      else $error("Vendor next pointer wrong");
   AST_VEND_LEN: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      rd_req && i_cfg_req.offset == `OFS_VEND_CAP |=>
      o_cfg_rdata[31:16] == `VEND_LENGTH)
      else $error("Vendor length wrong");
   AST_DATA_RSVD: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      rd_req && i_cfg_req.offset == `OFS_MSG_DATA |=>
      o_cfg_rdata[31:16] == 16'h0000)
      else $error("Data reserved half not zero");
   AST_REPLAY_RSVD: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      rd_req && i_cfg_req.offset == `OFS_REPLAY |=>
      o_cfg_rdata[31:15] == 17'h00000)
      else $error("Replay reserved bits not zero");
   AST_EN_AFTER_RST: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      $past(i_sys_rst) |->
      !msi_en_reg && !o_msg_write.valid)
      else $error("Message enable not clear after reset");
   AST_TEST_RST: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      $past(i_sys_rst) |->
      test0_reg == `TEST0_RST && test1_reg == `TEST1_RST)
      else $error("Test word reset value wrong");
   AST_ADDR_WRITE: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr_addr && i_cfg_req.byte_en == 4'hf |=>
      addr_reg == ($past(i_cfg_req.wdata) & `ADDR_MASK))
      else $error("Address write not aligned");
   AST_UADDR_USED: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      $rose(o_msg_write.valid) |->
      o_msg_write.addr[63:32] == $past(uaddr_reg))
      else $error("Upper address not carried");
   AST_LOAD_WINS: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_dflt_load && wr_replay |=>
      o_replay_user_val == $past(i_dflt_replay.user_replay))
      else $error("Software write beat default load");
   AST_FLAGS_RO: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !i_dflt_load |=>
      $stable(o_pm_cap_dis) && $stable(o_msi_cap_dis))
      else $error("Read-only disable flag changed");
   AST_LEGACY_PASS: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !msi_en_reg |->
      o_legacy_int == i_legacy_int && o_legacy_int_allow)
      else $error("Legacy interrupt blocked while messages off");
   AST_ISSUE_NEXT: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      msi_en_reg && pending_reg && state_reg == MSG_IDLE |=>
      o_msg_write.valid)
      else $error("Pending event not issued");

   COV_MSG: cover property (@(posedge i_mclk) disable iff (i_sys_rst) $rose(o_msg_write.valid));
   COV_DFLT: cover property (@(posedge i_mclk) disable iff (i_sys_rst) i_dflt_load);
   COV_EN: cover property (@(posedge i_mclk) disable iff (i_sys_rst) $rose(msi_en_reg));
   COV_LOAD_WINS: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_dflt_load && wr_replay);
   COV_MSG_DONE: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      $fell(o_msg_write.valid));
endmodule

// ===== rtl/msi_vendor_cap_map.svh
// Register offsets, field positions and reset values of the interrupt/vendor capability bank
// Contract
// - Interrupt-message enable bit 16 resets clear; no message request while clear. Code holds a request raised by the clearing edge until i_msg_done.
// - With enable set, messages may be issued and legacy wired interrupt stops.
// - Read-only 64-bit capable bit 23 reads one.
// - Address bits 31:2 writable, bits 1:0 reserved and zero.
// - Upper address writable, resets zero, used only when 64-bit capable.
// - Vendor capability identifier bits 7:0 read 09h.
// - Vendor capability next pointer bits 15:8 read B0h.
// - Vendor capability length bits 31:16 read 0034h.
// - Replay register bits 11:0 hold writable user replay value, reset zero.
// - Replay bit 12 selects user replay value for link layer; resets clear.
// - Test words at 68h and 6Ch reset to 0400_1060h and 0000_0800h.
// - Replay fields and disable flags loadable by management bus or serial memory.
// - Interrupt-message capability identifier at 4Ch reads 05h.
// - Interrupt-message capability next pointer reads 64h.
`ifndef MSI_VENDOR_CAP_MAP_SVH
`define MSI_VENDOR_CAP_MAP_SVH
`define OFS_MSG_CTRL 8'h4c
`define OFS_MSG_ADDR 8'h50
`define OFS_MSG_UADDR 8'h54
`define OFS_MSG_DATA 8'h58
`define OFS_VEND_CAP 8'h64
`define OFS_TEST0 8'h68
`define OFS_TEST1 8'h6c
`define OFS_REPLAY 8'h70
`define MSI_CAP_ID 8'h05
`define MSI_NEXT_PTR 8'h64
`define MSI_MM_CAPABLE 3'h2
`define BIT_MSI_EN 16
`define BIT_64B_CAP 23
`define VEND_CAP_ID 8'h09
`define VEND_NEXT_PTR 8'hb0
`define VEND_LENGTH 16'h0034
`define TEST0_RST 32'h04001060
`define TEST1_RST 32'h00000800
`define ADDR_MASK 32'hfffffffc
`define BIT_USER_REPLAY_EN 12
`define BIT_PM_CAP_DIS 13
`define BIT_MSI_CAP_DIS 14
`endif

// ===== rtl/msi_vendor_cap_pkg.sv
// Types shared by the interrupt/vendor capability bank
package msi_vendor_cap_pkg;
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] offset;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } cfg_req_t;
   typedef struct packed {
      logic [11:0] user_replay;
      logic user_replay_en;
      logic pm_cap_dis;
      logic msi_cap_dis;
   } replay_cfg_t;
   typedef struct packed {
      logic valid;
      logic [63:0] addr;
      logic [15:0] data;
   } msg_write_t;
   typedef enum logic [1:0] {
      MSG_IDLE,
      MSG_ISSUE
   } msg_state_t;
endpackage

// ===== sim/msg_sink_model.sv
// Upstream host model that accepts interrupt message writes
`timescale 1ns/1ns
module msg_sink_model
(
   input wire logic i_mclk,
   input wire msi_vendor_cap_pkg::msg_write_t i_msg_write,
   input wire logic [3:0] i_delay,
   output logic o_msg_done,
   output int o_count,
   output msi_vendor_cap_pkg::msg_write_t o_last
);
   import msi_vendor_cap_pkg::*;
   initial
   begin
      o_msg_done = 1'b0;
      o_count = 0;
      o_last = '0;
      forever
      begin
         @(posedge i_mclk);
         if (i_msg_write.valid === 1'b1)
         begin
            o_last <= i_msg_write;
            // Stall length is chosen by the bench
            repeat (i_delay) @(posedge i_mclk);
            o_msg_done <= 1'b1;
            o_count <= o_count + 1;
            @(posedge i_mclk);
            o_msg_done <= 1'b0;
            // Valid already fell at the previous edge; this edge is skipped as well
            @(posedge i_mclk);
         end
      end
   end
endmodule

// ===== sim/msi_vendor_capability_regs_tb.sv
// Self-checking bench for the interrupt-message and vendor capability registers
`timescale 1ns/1ns
module msi_vendor_capability_regs_tb;
   import msi_vendor_cap_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   cfg_req_t req = '0;
   replay_cfg_t dflt = '0;
   msg_write_t mw, last;
   logic [31:0] rdata, rd;
   logic ack, done, leg_allow, leg_out, ru_en, pm_dis, msi_dis;
   logic dflt_load = 1'b0;
   logic ev = 1'b0;
   logic leg_in = 1'b1;
   logic [11:0] ru_val;
   logic [3:0] dly = 4'h0;
   int cnt, err_total = 0, checks_done = 0, cycles = 0;
   logic [7:0] ofs_tab[9] = '{8'h4c, 8'h50, 8'h54, 8'h58, 8'h64, 8'h68, 8'h6c, 8'h70, 8'h80};

   msi_vendor_capability_regs dut_u (.i_mclk(clk), .i_sys_rst(rst), .i_cfg_req(req),
      .o_cfg_rdata(rdata), .o_cfg_ack(ack), .i_dflt_load(dflt_load), .i_dflt_replay(dflt),
      .i_event(ev), .i_msg_done(done), .o_msg_write(mw), .o_legacy_int_allow(leg_allow),
      .i_legacy_int(leg_in), .o_legacy_int(leg_out), .o_replay_user_en(ru_en),
      .o_replay_user_val(ru_val), .o_pm_cap_dis(pm_dis), .o_msi_cap_dis(msi_dis));
   msg_sink_model host_u (.i_mclk(clk), .i_msg_write(mw), .i_delay(dly), .o_msg_done(done),
      .o_count(cnt), .o_last(last));

   initial
   begin
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask

   task automatic cfg(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
      input logic [3:0] be, output logic [31:0] rdv);
      int n;
      @(posedge clk);
      req <= '{valid: 1'b1, write: wr, offset: ofs, byte_en: be, wdata: wd};
      @(posedge clk);
      req.valid <= 1'b0;
      n = 0;
      #1;
      while (ack !== 1'b1 && n < 4)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(ack, 1'b1);
      rdv = rdata;
   endtask

   task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
      cfg(1'b0, ofs, 32'h0, 4'hf, rd);
      check(rd, exp);
   endtask

   task automatic pulse_ev;
      @(posedge clk);
      ev <= 1'b1;
      @(posedge clk);
      ev <= 1'b0;
   endtask

   task automatic wait_cnt(input int want);
      int n;
      n = 0;
      while (cnt != want && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      check(cnt, want);
   endtask

   task automatic t_reset;
      logic [31:0] v[9] = '{32'h00846405, 0, 0, 0, 32'h0034b009, 32'h04001060,
         32'h00000800, 0, 0};
      check({leg_allow, ru_en, ru_val, pm_dis, msi_dis}, 16'h8000);
      foreach (v[i]) rdchk(ofs_tab[i], v[i]);
      $display("reset values test done");
   endtask

   task automatic t_write;
      logic [31:0] v[9] = '{32'h00f56405, 32'hfffffffc, 32'hffffffff, 32'h0000ffff,
         32'h0034b009, 32'hffffffff, 32'hffffffff, 32'h00001fff, 0};
      foreach (v[i]) cfg(1'b1, ofs_tab[i], 32'hffffffff, 4'hf, rd);
      foreach (v[i]) rdchk(ofs_tab[i], v[i]);
      check({ru_en, ru_val, pm_dis, msi_dis}, {1'b1, 12'hfff, 2'b00});
      cfg(1'b1, 8'h70, 32'h0, 4'h1, rd);
      rdchk(8'h70, 32'h00001f00);
      $display("write access test done");
   endtask

   task automatic t_msg;
      cfg(1'b1, 8'h4c, 32'h0, 4'hf, rd);
      cfg(1'b1, 8'h50, 32'h89abcdef, 4'hf, rd);
      cfg(1'b1, 8'h54, 32'h01234567, 4'hf, rd);
      cfg(1'b1, 8'h58, 32'hbeefa5a5, 4'hf, rd);
      pulse_ev;
      repeat (6) @(posedge clk);
      check(cnt, 0);
      check({leg_allow, leg_out}, 2'b11);
      cfg(1'b1, 8'h4c, 32'h00010000, 4'h4, rd);
      check({leg_allow, leg_out}, 2'b00);
      dly <= 4'h5;
      pulse_ev;
      wait_cnt(1);
      check(last.addr, 64'h0123456789abcdec);
      check(last.data, 16'ha5a5);
      dly <= 4'h0;
      pulse_ev;
      wait_cnt(2);
      repeat (3) @(posedge clk);
      check(mw.valid, 1'b0);
      $display("message test done");
   endtask

   task automatic t_load;
      @(posedge clk);
      dflt <= '{user_replay: 12'h5a3, user_replay_en: 1'b1, pm_cap_dis: 1'b1,
         msi_cap_dis: 1'b1};
      dflt_load <= 1'b1;
      // Same-cycle software write must lose to the load
      req <= '{valid: 1'b1, write: 1'b1, offset: 8'h70, byte_en: 4'hf, wdata: 32'h0};
      @(posedge clk);
      dflt_load <= 1'b0;
      req.valid <= 1'b0;
      rdchk(8'h70, 32'h000075a3);
      check({ru_en, ru_val, pm_dis, msi_dis}, {1'b1, 12'h5a3, 2'b11});
      $display("default load test done");
   endtask

   task automatic t_rerst;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({leg_allow, msi_dis}, 2'b10);
      rdchk(8'h68, 32'h04001060);
      rdchk(8'h70, 32'h00000000);
      $display("mid-run reset test done");
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         err_total++;
         results;
      end
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_write;
      t_msg;
      t_load;
      t_rerst;
      results;
   end
endmodule
